//--- inc/rtcrt_pkg.sv
// constants for the rtc rate trim and temperature compensation block
package rtcrt_pkg;
  localparam int ADDR_W = 16;
  localparam logic [15:0] OFF_TEMP_HI = 16'h2881;
  localparam logic [15:0] OFF_TEMP_LO = 16'h2882;
  localparam logic [15:0] OFF_LKP_ADDR = 16'h2887;
  localparam logic [15:0] OFF_LKP_DATA = 16'h2888;
  localparam logic [15:0] OFF_LKP_STB = 16'h2889;
  localparam logic [15:0] OFF_SHADOW_CTL = 16'h2890;
  localparam logic [15:0] OFF_DIV_TOP = 16'h289b;
  localparam logic [15:0] OFF_DIV_MID = 16'h289c;
  localparam logic [15:0] OFF_DIV_BOT = 16'h289d;
  localparam logic [15:0] OFF_ALM_MIN = 16'h289e;
  localparam logic [15:0] OFF_ALM_HR = 16'h289f;
  localparam logic [15:0] OFF_COMP_CTL = 16'h28a0;
  localparam logic [15:0] OFF_XTAL_TRIM = 16'h2504;
  // field positions
  localparam int BIT_AUTO_INC = 7;
  localparam int BIT_RD_STB = 1;
  localparam int BIT_WR_STB = 0;
  localparam int BIT_FREEZE = 7;
  localparam int BIT_COMP_EN = 5;
  // reset values
  localparam logic [6:0] TRIM_RST = 7'h40;
  localparam logic [16:0] DIV_P_RST = 17'h10000;
  localparam logic [1:0] DIV_Q_RST = 2'h0;
  localparam logic [18:0] DIV_NOMINAL = 19'h40000;
  // timing: eighth ticks per oscillator tick, ticks per ~500 hz update
  localparam logic [18:0] TICK_UNITS = 19'h00008;
  localparam int UPD_DIV_W = 6;
  localparam logic [8:0] ADDR_LIMIT_LO = -9'sd64;
  localparam logic [8:0] ADDR_LIMIT_HI = 9'sd63;
  // test mux selections
  localparam logic [1:0] TMUX_OFF = 2'h0;
  localparam logic [1:0] TMUX_1S = 2'h1;
  localparam logic [1:0] TMUX_4S = 2'h2;
endpackage

//--- hw/rtcrt_core.sv
// rtc rate control, temperature compensation lookup and alarm events
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - seven-bit crystal load trim, zero least load, all ones most load, linear.
// - digital rate adjust spans about plus or minus 488 ppm in 3.8 ppm steps.
// - new digital rate applies only from the next one-second boundary.
// - divisor lsb acts once per eight seconds; fraction spread over eight seconds.
// - divisor written to shadow while frozen, moved to counters when unfrozen.
// - with no adjustment one second is 32768 oscillator ticks.
// - four coarse plus fraction is eighth-ticks per second.
// - zero adjustment divisor is coarse 0x10000, fraction 0.
// - coarse split over three bytes, fraction in low bits of third byte.
// - test output offers one and four second quarter-high calibration waves.
// - with auto compensation on, divisor refreshed after every temperature result.
// - lookup address is temperature shifted right two, clamped to -64..63.
// - sign-extended table entry added to 0x40000 forms 19-bit divisor sum.
// - compensation result written back to divisor fields without software.
// - lookup address and data registers are read-write and reset to zero.
// - lookup strobe stays set until done, then clears and may step address.
// - auto-increment steps the address on each strobe; readable back.
// - without auto-increment address stays unchanged after access.
// - an event each second rollover and each minute rollover.
// - alarm event when minute and hour counts meet their targets.
// - second, minute and alarm events all drive external interrupt six.
// - unfreeze copies changed shadow on next ~500 hz tick; bit reads one till then.
module rtcrt_core
  import rtcrt_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // oscillator pin
  input wire logic oscillator_tick,
  // byte-wide register port
  input wire logic [rtcrt_pkg::ADDR_W-1:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  output logic [7:0] io_rdata,
  // temperature sensor result
  input wire logic [10:0] die_temp_result,
  input wire logic temp_done,
  // counter chain
  input wire logic [5:0] minute_count,
  input wire logic [4:0] hour_count,
  output logic second_boundary,
  // test mux and trim
  input wire logic [1:0] test_mux_sel,
  output logic test_mux_out_pin,
  output logic [6:0] crystal_load_trim,
  // events
  output logic second_tick_irq,
  output logic minute_tick_irq,
  output logic alarm_irq,
  output logic ext_int6_irq
);
  import rtcrt_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic osc_lvl;
    logic [6:0] trim;
    logic auto_inc;
    logic [6:0] addr;
    logic [7:0] data;
    logic rd_stb;
    logic wr_stb;
    logic [16:0] p;
    logic [1:0] q;
    logic [5:0] tmin;
    logic [4:0] thr;
    logic comp_en;
    logic freeze;
    logic copy_busy;
    logic changed;
    logic pend;
    logic [18:0] pend_sum;
    logic [18:0] act_sum;
    logic [18:0] acc;
    logic [UPD_DIV_W-1:0] upd_div;
    logic [1:0] sec4;
    logic comp_req;
    logic [6:0] comp_addr;
    logic [5:0] last_min;
    logic [4:0] last_hr;
    logic sec_irq;
    logic min_irq;
    logic alm_irq;
    logic int6;
    logic wave;
    logic sec_b;
    logic [7:0] rdata;
  } rtcrt_state_type;

  rtcrt_state_type st_reg;
  rtcrt_state_type st_next;
  logic [7:0] lut_mem [0:127];
  logic mem_we;

  // arithmetic shift then clamp to the signed 7-bit table range
  function automatic logic [6:0] rtcrt_lut_addr(input logic [10:0] t);
    logic signed [8:0] sh;
    sh = 9'(signed'(t) >>> 2);
    if (sh < signed'(ADDR_LIMIT_LO)) begin
      return ADDR_LIMIT_LO[6:0];
    end else if (sh > signed'(ADDR_LIMIT_HI)) begin
      return ADDR_LIMIT_HI[6:0];
    end
    return sh[6:0];
  endfunction

  function automatic logic [18:0] rtcrt_comp_sum(input logic [7:0] e);
    return DIV_NOMINAL + {{11{e[7]}}, e};
  endfunction

  logic osc_rise;
  logic upd_tick;
  logic [18:0] acc_add;
  logic [18:0] comp_val;
  logic lkp_op;

  always_comb begin
    st_next = st_reg;
    mem_we = 1'b0;
    osc_rise = st_reg.s2 && st_reg.s3 && !st_reg.osc_lvl;
    acc_add = st_reg.acc + TICK_UNITS;
    upd_tick = osc_rise && (st_reg.upd_div == '1);
    comp_val = rtcrt_comp_sum(lut_mem[st_reg.comp_addr]);
    lkp_op = st_reg.rd_stb || st_reg.wr_stb;
    // oscillator pin: three stages, change counted once stages two and three agree
    st_next.s1 = oscillator_tick;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if (st_reg.s2 == st_reg.s3) begin
      st_next.osc_lvl = st_reg.s3;
    end
    st_next.sec_b = 1'b0;
    st_next.sec_irq = 1'b0;
    st_next.min_irq = 1'b0;
    st_next.alm_irq = 1'b0;
    // second divider in eighth-ticks; remainder carries the fraction forward
    if (osc_rise) begin
      st_next.upd_div = st_reg.upd_div + 1'b1;
      if (acc_add >= st_reg.act_sum) begin
        st_next.acc = acc_add - st_reg.act_sum;
        st_next.sec_b = 1'b1;
        st_next.sec_irq = 1'b1;
        st_next.sec4 = st_reg.sec4 + 1'b1;
        if (st_reg.pend) begin
          st_next.act_sum = st_reg.pend_sum;
          st_next.pend = 1'b0;
        end
      end else begin
        st_next.acc = acc_add;
      end
    end
    // unfreeze copy lands on the next slow update tick
    if (upd_tick && st_reg.copy_busy && !st_reg.freeze) begin
      st_next.copy_busy = 1'b0;
      st_next.changed = 1'b0;
      if (st_reg.changed) begin
        st_next.pend_sum = {st_reg.p, st_reg.q};
        st_next.pend = 1'b1;
      end
    end
    // calibration waves: first quarter of each second, or the whole of every fourth second
    unique case (test_mux_sel)
      TMUX_1S: st_next.wave = st_reg.acc < {2'b00, st_reg.act_sum[18:2]};
      TMUX_4S: st_next.wave = st_reg.sec4 == 2'b00;
      default: st_next.wave = 1'b0;
    endcase
    // minute rollover and alarm match seen on counter-chain updates
    st_next.last_min = minute_count;
    st_next.last_hr = hour_count;
    if (minute_count != st_reg.last_min) begin
      st_next.min_irq = 1'b1;
    end
    if ((minute_count != st_reg.last_min || hour_count != st_reg.last_hr) &&
        minute_count == st_reg.tmin && hour_count == st_reg.thr) begin
      st_next.alm_irq = 1'b1;
    end
    st_next.int6 = st_next.sec_irq || st_next.min_irq || st_next.alm_irq;
    // table access: strobes take priority, compensation waits a cycle
    if (lkp_op) begin
      if (st_reg.wr_stb) begin
        mem_we = 1'b1;
      end else begin
        st_next.data = lut_mem[st_reg.addr];
      end
      st_next.rd_stb = 1'b0;
      st_next.wr_stb = 1'b0;
      if (st_reg.auto_inc) begin
        st_next.addr = st_reg.addr + 1'b1;
      end
    end else if (st_reg.comp_req) begin
      st_next.comp_req = 1'b0;
      st_next.p = comp_val[18:2];
      st_next.q = comp_val[1:0];
      st_next.pend_sum = comp_val;
      st_next.pend = 1'b1;
    end
    if (temp_done && st_reg.comp_en) begin
      st_next.comp_req = 1'b1;
      st_next.comp_addr = rtcrt_lut_addr(die_temp_result);
    end
    // register writes
    if (io_wr) begin
      unique case (io_addr)
        OFF_XTAL_TRIM: st_next.trim = io_wdata[6:0];
        OFF_LKP_ADDR: begin
          st_next.auto_inc = io_wdata[BIT_AUTO_INC];
          st_next.addr = io_wdata[6:0];
        end
        OFF_LKP_DATA: st_next.data = io_wdata;
        OFF_LKP_STB: begin
          // a set landing on the completing cycle is kept
          st_next.rd_stb = st_next.rd_stb || io_wdata[BIT_RD_STB];
          st_next.wr_stb = st_next.wr_stb || io_wdata[BIT_WR_STB];
        end
        OFF_SHADOW_CTL: begin
          st_next.freeze = io_wdata[BIT_FREEZE];
          if (st_reg.freeze && !io_wdata[BIT_FREEZE]) begin
            st_next.copy_busy = 1'b1;
          end
        end
        OFF_DIV_TOP: begin
          st_next.p[16:14] = io_wdata[2:0];
          st_next.changed = 1'b1;
        end
        OFF_DIV_MID: begin
          st_next.p[13:6] = io_wdata;
          st_next.changed = 1'b1;
        end
        OFF_DIV_BOT: begin
          st_next.p[5:0] = io_wdata[7:2];
          st_next.q = io_wdata[1:0];
          st_next.changed = 1'b1;
        end
        OFF_ALM_MIN: st_next.tmin = io_wdata[5:0];
        OFF_ALM_HR: st_next.thr = io_wdata[4:0];
        OFF_COMP_CTL: st_next.comp_en = io_wdata[BIT_COMP_EN];
        default: ;
      endcase
    end
    // register reads, answered one cycle after the read request
    if (io_rd) begin
      unique case (io_addr)
        OFF_TEMP_HI: st_next.rdata = die_temp_result[10:3];
        OFF_TEMP_LO: st_next.rdata = {die_temp_result[2:0], 5'h00};
        OFF_XTAL_TRIM: st_next.rdata = {1'b0, st_reg.trim};
        OFF_LKP_ADDR: st_next.rdata = {st_reg.auto_inc, st_reg.addr};
        OFF_LKP_DATA: st_next.rdata = st_reg.data;
        OFF_LKP_STB: st_next.rdata = {6'h00, st_reg.rd_stb, st_reg.wr_stb};
        OFF_SHADOW_CTL: st_next.rdata = {st_reg.freeze || st_reg.copy_busy, 7'h00};
        OFF_DIV_TOP: st_next.rdata = {5'h00, st_reg.p[16:14]};
        OFF_DIV_MID: st_next.rdata = st_reg.p[13:6];
        OFF_DIV_BOT: st_next.rdata = {st_reg.p[5:0], st_reg.q};
        OFF_ALM_MIN: st_next.rdata = {2'h0, st_reg.tmin};
        OFF_ALM_HR: st_next.rdata = {3'h0, st_reg.thr};
        OFF_COMP_CTL: st_next.rdata = {2'h0, st_reg.comp_en, 5'h00};
        default: st_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
      st_reg.trim <= TRIM_RST;
      st_reg.p <= DIV_P_RST;
      st_reg.q <= DIV_Q_RST;
      st_reg.pend_sum <= DIV_NOMINAL;
      st_reg.act_sum <= DIV_NOMINAL;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  // table is battery backed in the real part, so reset leaves it alone
  always_ff @(posedge core_clk) begin
    if (clk_en && mem_we) begin
      lut_mem[st_reg.addr] <= st_reg.data;
    end
  end

  assign io_rdata = st_reg.rdata;
  assign second_boundary = st_reg.sec_b;
  assign test_mux_out_pin = st_reg.wave;
  assign crystal_load_trim = st_reg.trim;
  assign second_tick_irq = st_reg.sec_irq;
  assign minute_tick_irq = st_reg.min_irq;
  assign alarm_irq = st_reg.alm_irq;
  assign ext_int6_irq = st_reg.int6;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  strobe_clears_a: assert property (st_reg.wr_stb && clk_en && !io_wr |=> !st_reg.wr_stb)
    else $error("write strobe did not clear");
  addr_step_a: assert property (st_reg.rd_stb && st_reg.auto_inc && clk_en && !io_wr
      |=> st_reg.addr == $past(st_reg.addr) + 7'h01)
    else $error("lookup address did not advance");
  addr_hold_a: assert property (st_reg.rd_stb && !st_reg.auto_inc && clk_en && !io_wr
      |=> st_reg.addr == $past(st_reg.addr))
    else $error("lookup address moved without auto increment");
  rate_at_sec_a: assert property (clk_en && !st_next.sec_b && !(!resetn)
      |=> st_reg.act_sum == $past(st_reg.act_sum))
    else $error("rate changed inside a second");
  comp_write_a: assert property (st_reg.comp_req && !lkp_op && clk_en && !io_wr
      |=> {st_reg.p, st_reg.q} == $past(comp_val) && st_reg.pend)
    else $error("compensation result not written back");
  comp_nominal_a: assert property (rtcrt_comp_sum(8'h00) == DIV_NOMINAL
      && rtcrt_comp_sum(8'hff) == 19'h3ffff)
    else $error("compensation sum wrong");
  addr_clamp_a: assert property (rtcrt_lut_addr(11'h400) == 7'h40
      && rtcrt_lut_addr(11'h3ff) == 7'h3f && rtcrt_lut_addr(11'h7fc) == 7'h7f)
    else $error("lookup address clamp wrong");
  freeze_reads_a: assert property (st_reg.copy_busy && io_rd && io_addr == OFF_SHADOW_CTL
      && clk_en |=> io_rdata[BIT_FREEZE])
    else $error("freeze bit read low before copy");
  int6_or_a: assert property (ext_int6_irq == (second_tick_irq || minute_tick_irq
      || alarm_irq))
    else $error("interrupt six does not merge events");
  alarm_once_a: assert property (alarm_irq && clk_en && minute_count == $past(minute_count)
      && hour_count == $past(hour_count) |=> !alarm_irq)
    else $error("alarm repeated while match held");
  sec_units_a: assert property (osc_rise && clk_en && st_reg.acc == 19'h0
      && st_reg.act_sum == DIV_NOMINAL |=> !second_boundary && st_reg.acc == TICK_UNITS)
    else $error("second divider step wrong");
  // compensation in the same cycle would overwrite the pending sum, so it is excluded
  copy_move_a: assert property (upd_tick && clk_en && st_reg.copy_busy && !st_reg.freeze
      && st_reg.changed && !st_reg.comp_req
      |=> st_reg.pend && st_reg.pend_sum[18:2] == $past(st_reg.p)
      && st_reg.pend_sum[1:0] == $past(st_reg.q))
    else $error("shadow divisor not moved");
  min_event_a: assert property (clk_en && minute_count != st_reg.last_min
      |=> minute_tick_irq)
    else $error("minute event missed");
endmodule // rtcrt_core
`default_nettype wire

//--- bench/tb_top.sv
// self-checking testbench for the rtc rate trim and compensation block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import rtcrt_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  logic oscillator_tick = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic [7:0] io_wdata = 8'h00;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [10:0] die_temp_result = 11'h000;
  logic temp_done = 1'b0;
  logic [5:0] minute_count = 6'h00;
  logic [4:0] hour_count = 5'h00;
  logic [1:0] test_mux_sel = 2'h0;
  logic [7:0] io_rdata;
  logic second_boundary;
  logic test_mux_out_pin;
  logic [6:0] crystal_load_trim;
  logic second_tick_irq;
  logic minute_tick_irq;
  logic alarm_irq;
  logic ext_int6_irq;
  int n_errors = 0;
  int num_checks = 0;
  int n_bnd = 0;
  int n_sec = 0;
  int n_min = 0;
  int n_alm = 0;
  int n_hi = 0;

  rtcrt_core u_dut (
    .core_clk(core_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .oscillator_tick(oscillator_tick),
    .io_addr(io_addr),
    .io_wdata(io_wdata),
    .io_wr(io_wr),
    .io_rd(io_rd),
    .io_rdata(io_rdata),
    .die_temp_result(die_temp_result),
    .temp_done(temp_done),
    .minute_count(minute_count),
    .hour_count(hour_count),
    .second_boundary(second_boundary),
    .test_mux_sel(test_mux_sel),
    .test_mux_out_pin(test_mux_out_pin),
    .crystal_load_trim(crystal_load_trim),
    .second_tick_irq(second_tick_irq),
    .minute_tick_irq(minute_tick_irq),
    .alarm_irq(alarm_irq),
    .ext_int6_irq(ext_int6_irq)
  );

  always #2 core_clk = ~core_clk;

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge core_clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge core_clk);
    io_wr = 1'b0;
  endtask

  // data sampled one and a half cycles after the taking edge, held until next read
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge core_clk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge core_clk);
    io_rd = 1'b0;
    @(negedge core_clk);
    d = io_rdata;
  endtask

  task automatic rchk(input string what, input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(what, {24'h0, d}, {24'h0, exp});
  endtask

  // set a lookup strobe and poll, bounded, until the block clears it
  task automatic lkp(input logic [7:0] stb);
    logic [7:0] d;
    wr(OFF_LKP_STB, stb);
    d = stb;
    for (int i = 0; i < 10 && d[1:0] != 2'b00; i++) begin
      rd(OFF_LKP_STB, d);
    end
    chk("lookup strobe", {24'h0, d}, 32'h0);
  endtask

  // ticks two cycles high, two low: the filter must see both levels agree
  task automatic tick(input int n);
    repeat (n) begin
      @(negedge core_clk);
      oscillator_tick = 1'b1;
      repeat (2) @(negedge core_clk);
      oscillator_tick = 1'b0;
      @(negedge core_clk);
    end
    repeat (12) @(negedge core_clk);
  endtask

  task automatic temp(input logic [10:0] t);
    @(negedge core_clk);
    die_temp_result = t;
    temp_done = 1'b1;
    @(negedge core_clk);
    temp_done = 1'b0;
    repeat (4) @(negedge core_clk);
  endtask

  always @(negedge core_clk) begin
    if (second_boundary === 1'b1) n_bnd++;
    if (second_tick_irq === 1'b1) n_sec++;
    if (minute_tick_irq === 1'b1) n_min++;
    if (alarm_irq === 1'b1) n_alm++;
    if (test_mux_out_pin === 1'b1) n_hi++;
    if ((ext_int6_irq | second_tick_irq | minute_tick_irq | alarm_irq) !== 1'b0) begin
      chk("int6", {31'h0, ext_int6_irq},
          {31'h0, second_tick_irq | minute_tick_irq | alarm_irq});
    end
  end

  initial begin
    // the first nominal second alone is 32768 ticks of four cycles
    #(4 * 140000);
    n_errors++;
    $display("watchdog expired");
    summarize();
  end

  initial begin
    logic [7:0] d;
    int gaps [4] = '{3, 2, 2, 2};
    repeat (3) @(negedge core_clk);
    resetn = 1'b1;
    chk("trim port", {25'h0, crystal_load_trim}, {25'h0, TRIM_RST});
    rchk("lkp addr", OFF_LKP_ADDR, 8'h00);
    rchk("lkp data", OFF_LKP_DATA, 8'h00);
    rchk("lkp stb", OFF_LKP_STB, 8'h00);
    rchk("div top", OFF_DIV_TOP, 8'h04);
    rchk("div mid", OFF_DIV_MID, 8'h00);
    rchk("div bot", OFF_DIV_BOT, 8'h00);
    rchk("comp", OFF_COMP_CTL, 8'h00);
    rchk("unmapped", 16'h2800, 8'h00);
    wr(OFF_XTAL_TRIM, 8'h7f);
    chk("trim max", {25'h0, crystal_load_trim}, 32'h7f);
    rchk("trim reg", OFF_XTAL_TRIM, 8'h7f);
    wr(OFF_XTAL_TRIM, 8'h00);
    chk("trim min", {25'h0, crystal_load_trim}, 32'h0);
    wr(OFF_ALM_MIN, 8'hff);
    wr(OFF_ALM_HR, 8'hff);
    rchk("alm min", OFF_ALM_MIN, 8'h3f);
    rchk("alm hr", OFF_ALM_HR, 8'h1f);
    wr(OFF_ALM_MIN, 8'h05);
    wr(OFF_ALM_HR, 8'h03);
    minute_count = 6'h05;
    repeat (6) @(negedge core_clk);
    chk("min irq", 32'(n_min), 32'd1);
    chk("no alarm", 32'(n_alm), 32'd0);
    hour_count = 5'h03;
    repeat (26) @(negedge core_clk);
    chk("alarm once", 32'(n_alm), 32'd1);
    minute_count = 6'h06;
    repeat (6) @(negedge core_clk);
    minute_count = 6'h05;
    repeat (6) @(negedge core_clk);
    chk("alarm rematch", 32'(n_alm), 32'd2);
    chk("min irq count", 32'(n_min), 32'd3);
    // a write while the clock enable is low must not land
    clk_en = 1'b0;
    wr(OFF_ALM_MIN, 8'h2a);
    clk_en = 1'b1;
    rchk("frozen write", OFF_ALM_MIN, 8'h05);
    // fill three entries with auto-increment
    wr(OFF_LKP_ADDR, 8'h80);
    for (int k = 0; k < 3; k++) begin
      wr(OFF_LKP_DATA, 8'(8'h11 * (k + 1)));
      lkp(8'h01);
    end
    rchk("addr after fill", OFF_LKP_ADDR, 8'h83);
    wr(OFF_LKP_ADDR, 8'h01);
    wr(OFF_LKP_DATA, 8'h00);
    lkp(8'h02);
    rchk("direct read", OFF_LKP_DATA, 8'h22);
    rchk("addr kept", OFF_LKP_ADDR, 8'h01);
    wr(OFF_LKP_ADDR, 8'h80);
    lkp(8'h02);
    rchk("auto read", OFF_LKP_DATA, 8'h11);
    rchk("addr stepped", OFF_LKP_ADDR, 8'h81);
    wr(OFF_LKP_ADDR, 8'h40);
    wr(OFF_LKP_DATA, 8'h80);
    lkp(8'h01);
    wr(OFF_LKP_ADDR, 8'h3f);
    wr(OFF_LKP_DATA, 8'h7f);
    lkp(8'h01);
    // tiny divisor p=4 q=2 through the shadow: 18 eighth-ticks a second
    wr(OFF_SHADOW_CTL, 8'h80);
    wr(OFF_DIV_TOP, 8'h00);
    wr(OFF_DIV_MID, 8'h00);
    wr(OFF_DIV_BOT, 8'h12);
    wr(OFF_SHADOW_CTL, 8'h00);
    rd(OFF_SHADOW_CTL, d);
    chk("freeze pending", {31'h0, d[7]}, 32'h1);
    rchk("div bot shadow", OFF_DIV_BOT, 8'h12);
    chk("mux off", {31'h0, test_mux_out_pin}, 32'h0);
    tick(32767);
    chk("no boundary yet", 32'(n_bnd), 32'd0);
    rd(OFF_SHADOW_CTL, d);
    chk("freeze done", {31'h0, d[7]}, 32'h0);
    tick(1);
    chk("first second", 32'(n_bnd), 32'd1);
    test_mux_sel = TMUX_1S;
    // remainder carries over, so seconds run 3,2,2,2 ticks
    for (int k = 0; k < 8; k++) begin
      tick(gaps[k % 4] - 1);
      chk("early boundary", 32'(n_bnd), 32'(1 + k));
      tick(1);
      chk("boundary", 32'(n_bnd), 32'(2 + k));
    end
    chk("wave 1s high", {31'h0, test_mux_out_pin}, 32'h1);
    tick(1);
    chk("wave 1s low", {31'h0, test_mux_out_pin}, 32'h0);
    test_mux_sel = TMUX_4S;
    repeat (2) @(negedge core_clk);
    chk("wave 4s low", {31'h0, test_mux_out_pin}, 32'h0);
    // three more seconds bring the four-second count back to zero
    tick(6);
    chk("four seconds", 32'(n_bnd), 32'd12);
    chk("wave 4s high", {31'h0, test_mux_out_pin}, 32'h1);
    chk("sec irq", 32'(n_sec), 32'(n_bnd));
    chk("wave high", {31'h0, n_hi > 0}, 32'h1);
    wr(OFF_COMP_CTL, 8'h20);
    rchk("comp on", OFF_COMP_CTL, 8'h20);
    temp(11'h400);
    rchk("temp hi", OFF_TEMP_HI, 8'h80);
    rchk("comp lo top", OFF_DIV_TOP, 8'h03);
    rchk("comp lo mid", OFF_DIV_MID, 8'hff);
    rchk("comp lo bot", OFF_DIV_BOT, 8'h80);
    temp(11'h3ff);
    rchk("temp lo", OFF_TEMP_LO, 8'he0);
    rchk("comp hi top", OFF_DIV_TOP, 8'h04);
    rchk("comp hi mid", OFF_DIV_MID, 8'h00);
    rchk("comp hi bot", OFF_DIV_BOT, 8'h7f);
    wr(OFF_COMP_CTL, 8'h00);
    temp(11'h400);
    rchk("comp off", OFF_DIV_BOT, 8'h7f);
    summarize();
  end
endmodule // tb_top
`default_nettype wire
